// File: hw/sto_seq_pkg.sv
package sto_seq_pkg;

    // ------------------------------------------------------------------
    // Timebase
    // ------------------------------------------------------------------
    localparam int CLK_FREQ_HZ        = 50_000_000;  // Core clock rate
    localparam int TICK_MS            = 1;           // Tick period in ms
    localparam int TICK_CYCLES        = CLK_FREQ_HZ / 1000 * TICK_MS;
    localparam int TICK_W             = 16;          // Prescaler width

    // ------------------------------------------------------------------
    // Delays in milliseconds
    // ------------------------------------------------------------------
    localparam int MS_W               = 16;          // Delay counter width
    localparam logic [MS_W-1:0] REACT_DELAY_MS   = 16'h0005; // Reaction
    localparam logic [MS_W-1:0] DISCREP_DEF_MS   = 16'h0064; // 100 ms
    localparam logic [MS_W-1:0] HOLD_LOW_MIN_MS  = 16'h0005; // > 5 ms
    localparam logic [MS_W-1:0] LEAD_LOW_MIN_MS  = 16'h0000; // 0 ms

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    // Two torque-off channels sampled together
    typedef struct packed {
        logic channel_a;
        logic channel_b;
    } sto_pair_s;

    // Configured delays in ms
    typedef struct packed {
        logic [MS_W-1:0] discrepancy;
        logic [MS_W-1:0] brake_engage;
        logic [MS_W-1:0] brake_release;
    } delay_cfg_s;

    // Drive sequencing states, Gray along the run path
    typedef enum logic [2:0] {
        ST_OFF      = 3'b000,
        ST_RELEASE  = 3'b001,
        ST_RUN      = 3'b011,
        ST_ENGAGE   = 3'b010,
        ST_FAULT    = 3'b110
    } drive_state_e;

endpackage : sto_seq_pkg

// File: hw/ms_delay.sv
`timescale 1ns/100ps

// Restartable millisecond timer: done once more than limit ticks have
// passed with start held, so a wait of limit ms is never cut short by
// the phase of the free-running tick
module ms_delay
    import sto_seq_pkg::*;
(
    input  wire logic            core_clk,
    input  wire logic            resetn,
    input  wire logic            tick,
    input  wire logic            start,
    input  wire logic [MS_W-1:0] limit,
    output logic                 done
);

    logic [MS_W:0]   count_r;   // Elapsed ms while start held
    logic            hit;       // Limit passed

    assign hit  = (count_r > {1'b0, limit});

    // ------------------------------------------------------------------
    // Counter
    // ------------------------------------------------------------------
    // Clears whenever start drops, so a withdrawn trigger restarts
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            count_r <= '0;
        end else if (!start) begin
            count_r <= '0;
        end else if (tick && !hit) begin
            count_r <= count_r + 1'b1;
        end
    end

    assign done = start && hit;

endmodule : ms_delay

// File: hw/torque_off_restart_sequencer.sv
`timescale 1ns/100ps

module torque_off_restart_sequencer
    import sto_seq_pkg::*;
#(parameter int MS_CYCLES = TICK_CYCLES) (
    input  wire logic       core_clk,
    input  wire logic       resetn,
    input  wire logic       torque_off_channel_a,
    input  wire logic       torque_off_channel_b,
    input  wire logic       drive_enable_input,
    input  wire logic       speed_zero,
    input  delay_cfg_s      delay_cfg,
    input  wire logic       error_clear,
    output logic            pwm_block,
    output logic            driver_supply_on,
    output logic            internal_enable,
    output logic            brake_release,
    output logic            setpoint_enable,
    output logic            feedback_contact,
    output logic            discrepancy_error,
    output logic            restart_interlock
);

    // ------------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------------
    logic [2:0]      meta_r;        // First stage, pins
    logic [2:0]      sync_r;        // Second stage, safe to read
    sto_pair_s       sto_s;         // Synchronised channels
    logic            enable_s;      // Synchronised drive enable

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            meta_r <= 3'h0;
            sync_r <= 3'h0;
        end else begin
            meta_r <= {torque_off_channel_a, torque_off_channel_b,
                       drive_enable_input};
            sync_r <= meta_r;
        end
    end

    assign sto_s.channel_a = sync_r[2];
    assign sto_s.channel_b = sync_r[1];
    assign enable_s        = sync_r[0];

    // ------------------------------------------------------------------
    // Millisecond tick
    // ------------------------------------------------------------------
    logic [TICK_W-1:0] pre_r;       // Prescaler count
    logic              tick;        // One pulse per ms

    assign tick = (pre_r == TICK_W'(MS_CYCLES - 1));

    // Free-running prescaler that forms the ms timebase
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            pre_r <= '0;
        end else if (tick) begin
            pre_r <= '0;
        end else begin
            pre_r <= pre_r + 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // Hardware switching paths
    // ------------------------------------------------------------------
    logic pwm_block_r;              // PWM block follows channel A
    logic supply_r;                 // Driver supply follows channel B

    // Direct paths, one flop past the synchroniser
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            pwm_block_r <= 1'b1;
            supply_r    <= 1'b0;
        end else begin
            pwm_block_r <= !sto_s.channel_a;
            supply_r    <= sto_s.channel_b;
        end
    end

    assign pwm_block        = pwm_block_r;
    assign driver_supply_on = supply_r;

    // ------------------------------------------------------------------
    // Firmware reaction delay on torque-off status
    // ------------------------------------------------------------------
    logic both_high;                // Both channels released
    logic sto_free_r;               // Status seen by drive control
    logic react_start;              // Status differs from inputs
    logic react_done;               // Reaction delay elapsed

    assign both_high   = sto_s.channel_a && sto_s.channel_b;
    assign react_start = (both_high != sto_free_r);

    ms_delay u_react (
        .core_clk (core_clk),
        .resetn   (resetn),
        .tick     (tick),
        .start    (react_start),
        .limit    (REACT_DELAY_MS - 1'b1),
        .done     (react_done)
    );

    // Adopt new status only once stable for the reaction delay
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            sto_free_r <= 1'b0;
        end else if (react_done) begin
            sto_free_r <= both_high;
        end
    end

    // ------------------------------------------------------------------
    // Discrepancy monitor
    // ------------------------------------------------------------------
    logic mismatch;                 // Channels differ
    logic discrep_done;             // Mismatch outlasted limit
    logic discrep_r;                // Sticky error

    assign mismatch = sto_s.channel_a ^ sto_s.channel_b;

    ms_delay u_discrep (
        .core_clk (core_clk),
        .resetn   (resetn),
        .tick     (tick),
        .start    (mismatch),
        .limit    (delay_cfg.discrepancy),
        .done     (discrep_done)
    );

    // Error is sticky; a new mismatch timeout wins over the clear
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            discrep_r <= 1'b0;
        end else if (discrep_done) begin
            discrep_r <= 1'b1;
        end else if (error_clear) begin
            discrep_r <= 1'b0;
        end
    end

    assign discrepancy_error = discrep_r;

    // ------------------------------------------------------------------
    // Feedback contact
    // ------------------------------------------------------------------
    logic fb_r;                     // Closed in safe state

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            fb_r <= 1'b0;
        end else begin
            fb_r <= !sto_s.channel_a && !sto_s.channel_b;
        end
    end

    assign feedback_contact = fb_r;

    // ------------------------------------------------------------------
    // Restart interlock on drive enable
    // ------------------------------------------------------------------
    logic hold_start;               // Enable low with status free
    logic hold_done;                // Enable low long enough
    logic armed_r;                  // Restart permitted
    logic free_q_r;                 // Previous status, edge detect
    logic free_rise;                // Status became free

    assign free_rise  = sto_free_r && !free_q_r;
    assign hold_start = sto_free_r && !enable_s && !armed_r;

    ms_delay u_hold (
        .core_clk (core_clk),
        .resetn   (resetn),
        .tick     (tick),
        .start    (hold_start),
        .limit    (HOLD_LOW_MIN_MS),
        .done     (hold_done)
    );

    // Arm only after enable stays low past the hold time; loss or a
    // new rise of the free status disarms, an early rise of enable restarts the hold
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            armed_r  <= 1'b0;
            free_q_r <= 1'b0;
        end else begin
            free_q_r <= sto_free_r;
            if (!sto_free_r || free_rise) begin
                armed_r <= 1'b0;
            end else if (hold_done) begin
                armed_r <= 1'b1;
            end
        end
    end

    assign restart_interlock = !armed_r;

    // ------------------------------------------------------------------
    // Drive and brake sequencing
    // ------------------------------------------------------------------
    drive_state_e state_r;          // Sequencer state
    drive_state_e state_nxt;        // Next state
    logic         run_req;          // Enable with restart permitted
    logic         rel_done;         // Brake release delay elapsed
    logic         eng_done;         // Brake engage delay elapsed

    assign run_req = sto_free_r && armed_r && enable_s;

    ms_delay u_release (
        .core_clk (core_clk),
        .resetn   (resetn),
        .tick     (tick),
        .start    (state_r == ST_RELEASE),
        .limit    (delay_cfg.brake_release),
        .done     (rel_done)
    );
    ms_delay u_engage (
        .core_clk (core_clk),
        .resetn   (resetn),
        .tick     (tick),
        .start    (state_r == ST_ENGAGE),
        .limit    (delay_cfg.brake_engage),
        .done     (eng_done)
    );

    // Next-state selection
    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            ST_OFF: begin
                if (run_req) state_nxt = ST_RELEASE;
            end
            ST_RELEASE: begin
                if (!sto_free_r)    state_nxt = ST_OFF;
                else if (!enable_s) state_nxt = ST_OFF;
                else if (rel_done)  state_nxt = ST_RUN;
            end
            ST_RUN: begin
                if (!sto_free_r)    state_nxt = ST_OFF;
                else if (!enable_s && speed_zero)
                    state_nxt = ST_ENGAGE;
            end
            ST_ENGAGE: begin
                if (!sto_free_r)    state_nxt = ST_OFF;
                else if (eng_done)  state_nxt = ST_OFF;
            end
            ST_FAULT: begin
                if (!discrep_r)     state_nxt = ST_OFF;
            end
            default: state_nxt = ST_OFF;
        endcase
        if (discrep_r) state_nxt = ST_FAULT;
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            state_r <= ST_OFF;
        end else begin
            state_r <= state_nxt;
        end
    end

    // Registered drive outputs decoded from the state; brake also held until zero speed
    logic en_r;                     // Internal drive enable
    logic brk_r;                    // Brake released
    logic sp_r;                     // Setpoint enabled

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            en_r  <= 1'b0;
            brk_r <= 1'b0;
            sp_r  <= 1'b0;
        end else begin
            en_r  <= (state_nxt != ST_OFF) && (state_nxt != ST_FAULT);
            brk_r <= (state_nxt == ST_RELEASE) || (state_nxt == ST_RUN) ||
                     (brk_r && !speed_zero);
            sp_r  <= (state_nxt == ST_RUN);
        end
    end

    assign internal_enable = en_r;
    assign brake_release   = brk_r;
    assign setpoint_enable = sp_r;

endmodule : torque_off_restart_sequencer

// File: testbench/safety_switch_model.sv
`timescale 1ns/100ps

// Behavioural safety relay driving the torque-off pins
module safety_switch_model
    import sto_seq_pkg::*;
#(parameter int MS_CYCLES = TICK_CYCLES) (
    input  wire logic core_clk,
    output logic      torque_off_channel_a,
    output logic      torque_off_channel_b,
    output logic      drive_enable_input
);
    // All contacts open at power up
    initial begin
        torque_off_channel_a = 1'b0;
        torque_off_channel_b = 1'b0;
        drive_enable_input   = 1'b0;
    end

    // Waits whole milliseconds of core clock
    task automatic wait_ms(input int n);
        repeat (n * MS_CYCLES) @(negedge core_clk);
    endtask : wait_ms

    // Moves enable and both channels just after a falling edge
    task automatic set_pins(input logic en, input logic a, input logic b);
        @(negedge core_clk);
        drive_enable_input   = en;
        torque_off_channel_a = a;
        torque_off_channel_b = b;
    endtask : set_pins

    // Restart: enable kept low until well past the free status
    task automatic switch_on();
        set_pins(1'b0, 1'b1, 1'b1);
        wait_ms(14);
        set_pins(1'b1, 1'b1, 1'b1);
    endtask : switch_on

    // Controlled stop: undelayed enable, off-delayed channels
    task automatic controlled_stop_one(input int off_ms);
        set_pins(1'b0, 1'b1, 1'b1);
        wait_ms(off_ms);
        set_pins(1'b0, 1'b0, 1'b0);
    endtask : controlled_stop_one
endmodule : safety_switch_model

// File: testbench/sequencer_monitor.sv
`timescale 1ns/100ps

// Port-level checker of the restart sequencer
module sequencer_monitor
    import sto_seq_pkg::*;
#(parameter int MS_CYCLES = TICK_CYCLES) (
    input wire logic       core_clk,
    input wire logic       resetn,
    input wire logic       torque_off_channel_a,
    input wire logic       torque_off_channel_b,
    input wire logic       drive_enable_input,
    input wire logic       speed_zero,
    input wire delay_cfg_s delay_cfg,
    input wire logic       error_clear,
    input wire logic       pwm_block,
    input wire logic       driver_supply_on,
    input wire logic       internal_enable,
    input wire logic       brake_release,
    input wire logic       setpoint_enable,
    input wire logic       feedback_contact,
    input wire logic       discrepancy_error,
    input wire logic       restart_interlock
);
    // ------------------------------------------------------------
    // Helper counters
    // ------------------------------------------------------------
    logic [31:0]      rel_cnt_r; // Cycles with brake released
    logic [31:0]      eng_cnt_r; // Cycles of engage hold
    wire logic [31:0] rel_min;   // Shortest legal release wait
    wire logic [31:0] eng_min;   // Shortest legal engage hold
    assign rel_min = 32'(delay_cfg.brake_release) * 32'(MS_CYCLES);
    assign eng_min = 32'(delay_cfg.brake_engage) * 32'(MS_CYCLES);

    // Counts release time and engage hold time in cycles
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            rel_cnt_r <= 32'h0;
            eng_cnt_r <= 32'h0;
        end else begin
            rel_cnt_r <= brake_release ? rel_cnt_r + 32'h1 : 32'h0;
            eng_cnt_r <= (internal_enable && !brake_release) ?
                         eng_cnt_r + 32'h1 : 32'h0;
        end
    end

    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!resetn);

    property p_pwm;
        $changed(torque_off_channel_a) |->
            ##3 (pwm_block == !$past(torque_off_channel_a, 3));
    endproperty
    property p_supply;
        $changed(torque_off_channel_b) |->
            ##3 (driver_supply_on == $past(torque_off_channel_b, 3));
    endproperty
    property p_fb;
        feedback_contact |-> !$past(torque_off_channel_a, 3) &&
                             !$past(torque_off_channel_b, 3);
    endproperty
    property p_ien_sto;
        $rose(internal_enable) |-> !pwm_block && driver_supply_on;
    endproperty
    property p_interlock;
        $rose(internal_enable) |-> !$past(restart_interlock);
    endproperty
    property p_spt;
        setpoint_enable |-> brake_release && internal_enable;
    endproperty
    property p_rel;
        $rose(setpoint_enable) |-> rel_cnt_r >= rel_min;
    endproperty
    property p_eng;
        $fell(internal_enable) && !pwm_block && !discrepancy_error
            |-> eng_cnt_r >= eng_min;
    endproperty
    property p_brake;
        $fell(brake_release) |-> $past(speed_zero);
    endproperty
    property p_err;
        discrepancy_error && !error_clear |=> discrepancy_error;
    endproperty

    a_pwm: assert property (p_pwm)
        else $error("pwm block does not follow channel a");
    a_supply: assert property (p_supply)
        else $error("driver supply does not follow channel b");
    a_fb: assert property (p_fb)
        else $error("feedback closed with a channel high");
    a_ien_sto: assert property (p_ien_sto)
        else $error("enable rose while torque off");
    a_interlock: assert property (p_interlock)
        else $error("enable rose while restart locked");
    a_spt: assert property (p_spt)
        else $error("setpoint without released brake");
    a_rel: assert property (p_rel)
        else $error("setpoint before release delay");
    a_eng: assert property (p_eng)
        else $error("enable dropped before engage delay");
    a_brake: assert property (p_brake)
        else $error("brake engaged while turning");
    a_err: assert property (p_err)
        else $error("discrepancy error not sticky");

    c_run: cover property ($rose(setpoint_enable));
    c_err: cover property ($rose(discrepancy_error));
    c_stop: cover property ($fell(internal_enable) && !pwm_block);
    c_hold: cover property ($fell(internal_enable) && brake_release);
endmodule : sequencer_monitor

bind torque_off_restart_sequencer sequencer_monitor
    #(.MS_CYCLES(MS_CYCLES)) mon (
    .core_clk, .resetn, .torque_off_channel_a, .torque_off_channel_b,
    .drive_enable_input, .speed_zero, .delay_cfg, .error_clear,
    .pwm_block, .driver_supply_on, .internal_enable, .brake_release,
    .setpoint_enable, .feedback_contact, .discrepancy_error,
    .restart_interlock
);

// File: testbench/tb_top.sv
`timescale 1ns/100ps

// Self-checking bench of the restart sequencer
module tb_top
    import sto_seq_pkg::*;
;
    localparam int BENCH_MS = 500;    // Short ms tick keeps the run brief
    localparam int LIMIT = 60_000;    // About 75 bench ms plus margin
    logic        core_clk, resetn, speed_zero, error_clear;
    delay_cfg_s  delay_cfg;       // Configured delays
    wire logic   torque_off_channel_a, torque_off_channel_b;
    wire logic   drive_enable_input, restart_interlock;
    wire logic   pwm_block, driver_supply_on, internal_enable;
    wire logic   brake_release, setpoint_enable, feedback_contact;
    wire logic   discrepancy_error;
    logic [6:0]  last_r, exp_v;   // Last seen and expected outputs
    logic [6:0]  exp_q[$];        // Expected output changes
    logic [31:0] seed;            // Random state
    int          failures, n_checks, cyc;
    wire logic [6:0] outv = {pwm_block, driver_supply_on,
        feedback_contact, internal_enable, brake_release,
        setpoint_enable, discrepancy_error};

    torque_off_restart_sequencer #(.MS_CYCLES(BENCH_MS)) uut (
        .core_clk, .resetn, .torque_off_channel_a, .torque_off_channel_b,
        .drive_enable_input, .speed_zero, .delay_cfg, .error_clear,
        .pwm_block, .driver_supply_on, .internal_enable, .brake_release,
        .setpoint_enable, .feedback_contact, .discrepancy_error,
        .restart_interlock
    );
    safety_switch_model #(.MS_CYCLES(BENCH_MS)) partner (
        .core_clk, .torque_off_channel_a, .torque_off_channel_b,
        .drive_enable_input
    );

    // Shift register random source
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr

    // Notes one expected output vector
    task automatic expect_v(input logic [6:0] v);
        exp_q.push_back(v);
    endtask : expect_v

    // Compares the restart interlock with its expected level
    task automatic check_lock(input logic v);
        n_checks++;
        if (restart_interlock !== v) begin
            failures++;
            $display("CHECK FAILED t=%0t interlock %b", $time,
                     restart_interlock);
        end
    endtask : check_lock

    // Prints the verdict and ends the run
    task automatic stop_test();
        if (failures == 0 && n_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : stop_test

    // Clock of 20 ns
    initial begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end

    // Hang guard
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == LIMIT) begin
            failures++;
            $display("CHECK FAILED t=%0t timeout", $time);
            stop_test();
        end
    end

    // Compares each output change with the oldest note
    always @(negedge core_clk) begin
        if (resetn && outv !== last_r) begin
            exp_v = (exp_q.size() > 0) ? exp_q.pop_front() : 7'hX;
            n_checks++;
            if (outv !== exp_v) begin
                failures++;
                $display("CHECK FAILED t=%0t out %h exp %h", $time,
                         outv, exp_v);
            end
            last_r = outv;
        end
    end

    // Main sequence
    initial begin
        resetn = 1'b0;
        speed_zero = 1'b1;
        error_clear = 1'b0;
        failures = 0;
        n_checks = 0;
        cyc = 0;
        last_r = 7'h40;
        seed = lfsr(32'hD03B);
        delay_cfg.discrepancy = 16'h0002;
        delay_cfg.brake_engage = 16'h0001 + {14'h0000, seed[1:0]};
        delay_cfg.brake_release = 16'h0001 + {14'h0000, seed[3:2]};
        repeat (4) @(negedge core_clk);
        expect_v(7'h50);
        resetn = 1'b1;
        repeat (10) @(negedge core_clk);
        // Two restarts around a controlled stop, then torque off
        for (int k = 0; k < 2; k++) begin
            check_lock(1'b1);
            expect_v(7'h20);
            expect_v(7'h2C);
            expect_v(7'h2E);
            partner.switch_on();
            check_lock(1'b0);
            partner.wait_ms(6);
            if (k == 0) begin
                speed_zero = 1'b0;
                expect_v(7'h28);
                expect_v(7'h20);
                expect_v(7'h50);
                fork
                    partner.controlled_stop_one(14);
                    begin
                        partner.wait_ms(1 + int'(seed[5:4]));
                        speed_zero = 1'b1;
                    end
                join
                // Status drops, so the next restart is interlocked anew
                partner.wait_ms(7);
            end
        end
        // Torque off while turning: brake held until zero speed
        expect_v(7'h5E);
        expect_v(7'h54);
        expect_v(7'h50);
        speed_zero = 1'b0;
        partner.set_pins(1'b1, 1'b0, 1'b0);
        partner.wait_ms(8);
        check_lock(1'b1);
        speed_zero = 1'b1;
        repeat (10) @(negedge core_clk);
        expect_v(7'h00);
        expect_v(7'h01);
        partner.set_pins(1'b0, 1'b1, 1'b0);
        partner.wait_ms(5);
        expect_v(7'h51);
        partner.set_pins(1'b0, 1'b0, 1'b0);
        repeat (10) @(negedge core_clk);
        expect_v(7'h50);
        error_clear = 1'b1;
        @(negedge core_clk);
        error_clear = 1'b0;
        repeat (10) @(negedge core_clk);
        n_checks++;
        if (exp_q.size() != 0) begin
            failures++;
            $display("CHECK FAILED t=%0t missing changes", $time);
        end
        stop_test();
    end
endmodule : tb_top
